// *** design/bbe_evaluator.sv ***
// beam evaluation, blanking teach, indications and register slave
// Operation
// (RULE1) reduced resolution excuses two adjacent blocked beams, not sync
// (RULE2) any unexcused blockage switches both safety outputs off
// (RULE3) reduced resolution with clear field flashes green status
// (RULE4) several blanked areas allowed, separated by an unblanked beam
// (RULE5) sync beam is never accepted as blanked
// (RULE6) blanked beams must stay blocked for outputs to stay on
// (RULE7) a blanked beam going clear enters lockout
// (RULE8) blanked areas flash green zone indicators during operation
// (RULE9) teach switch pattern plus power-up or valid reset enters teach mode
// (RULE10) valid reset is a closure of 0.25 to 2 s then release
// (RULE11) teach mode alternates code and blocked count, reset off, red
// (RULE12) normal switches in teach store blanked beams and show done
// (RULE13) after teach a valid reset or power cycle resumes operation
// (RULE14) teaching with clear field leaves no blanked beams
// (RULE15) blanking may also be configured remotely when enabled
// (RULE16) trip mode: red while blocked, green again once clear
// (RULE17) latch mode: red until reset; reset lamp steady, flashes awaiting
// (RULE18) blocked beams light their zone indicators red
// (RULE19) downstream cascade blockage shows on this status indicator
// (RULE20) latch mode: outputs on only after clear field and manual reset; after power-up the code turns them on with a clear field and no reset
// (RULE21) blocked sync beam: zone one red, all others off
// (RULE22) too short or too long closures are not a reset
`timescale 1ns/1ps
module bbe_evaluator #(
  parameter int unsigned BEAMS = bbe_pkg::BEAMS,
  parameter int unsigned RST_MIN_CYC = bbe_pkg::RST_MIN_CYC,
  parameter int unsigned RST_MAX_CYC = bbe_pkg::RST_MAX_CYC,
  parameter int unsigned BLINK_HALF_CYC = bbe_pkg::BLINK_HALF_CYC
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [BEAMS-1:0] BEAM_BLOCKED_IN,
  input wire logic CASCADE_BLOCKED_IN,
  input wire logic [3:0] DIP_IN,
  input wire logic RESET_SW_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic [1:0] SAFETY_PAIR_OUT,
  output logic STATUS_GREEN_OUT,
  output logic STATUS_RED_OUT,
  output logic RESET_YEL_OUT,
  output logic [BEAMS-1:0] ZONE_GREEN_OUT,
  output logic [BEAMS-1:0] ZONE_RED_OUT,
  output logic [7:0] DISP_CODE_OUT
);
  bbe_tick_if tk ();

  bbe_flasher #(.HALF_CYC(BLINK_HALF_CYC)) u_flash (.clk_in(CORE_CLK_IN),
    .rst_in(RST_IN), .tk(tk.flasher));
  bbe_rst_qual #(.MIN_CYC(RST_MIN_CYC), .MAX_CYC(RST_MAX_CYC)) u_qual (
    .clk_in(CORE_CLK_IN), .rst_in(RST_IN), .tk(tk.qual));

  assign tk.sw_closed = RESET_SW_IN;

  function automatic logic [7:0] count_ones(input logic [BEAMS-1:0] v);
    logic [7:0] n;
    n = 8'h0;
    for (int i = 0; i < BEAMS; i++)
      n = n + {7'h0, v[i]};
    return n;
  endfunction

  bbe_pkg::bbe_state_t state_reg, state_next;
  logic [BEAMS-1:0] blank_reg, excess;
  logic [7:0] excess_n, wr_addr_reg;
  logic remote_en_reg, wr_pend_reg, sync_blk, rr_en, latch_mode;
  logic dip_normal, dip_teach, rr_ok, trip, blank_lost;

  assign latch_mode = DIP_IN[0];
  assign rr_en = DIP_IN[1];
  assign dip_normal = DIP_IN[1:0] == DIP_IN[3:2];
  assign dip_teach = DIP_IN == bbe_pkg::DIP_TEACH;
  assign sync_blk = BEAM_BLOCKED_IN[0];
  assign excess = BEAM_BLOCKED_IN & ~blank_reg;
  assign excess_n = count_ones(excess);
  // a pair must be adjacent; the sync beam is never excused
  assign rr_ok = rr_en && !sync_blk && (excess_n < 8'h2 ||
    (excess_n == 8'h2 && |(excess & (excess >> 1)))); // [RULE1]
  assign trip = sync_blk || CASCADE_BLOCKED_IN
    || (excess != '0 && !rr_ok); // [RULE2] [RULE19]
  assign blank_lost = |(blank_reg & ~BEAM_BLOCKED_IN); // [RULE6]

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      bbe_pkg::ST_INIT:
        state_next = dip_teach ? bbe_pkg::ST_TEACH : // [RULE9]
          (dip_normal ? bbe_pkg::ST_RUN : bbe_pkg::ST_LOCKOUT);
      bbe_pkg::ST_RUN, bbe_pkg::ST_LATCHED:
        if (!dip_normal || blank_lost)
          state_next = bbe_pkg::ST_LOCKOUT; // [RULE7]
        else if (state_reg == bbe_pkg::ST_RUN && trip && latch_mode)
          state_next = bbe_pkg::ST_LATCHED;
        else if (state_reg == bbe_pkg::ST_LATCHED && !trip && tk.rst_valid)
          state_next = bbe_pkg::ST_RUN; // [RULE20]
      bbe_pkg::ST_LOCKOUT:
        if (tk.rst_valid && dip_teach)
          state_next = bbe_pkg::ST_TEACH; // [RULE9]
        else if (tk.rst_valid && dip_normal)
          state_next = bbe_pkg::ST_RUN;
      bbe_pkg::ST_TEACH:
        if (dip_normal)
          state_next = bbe_pkg::ST_DONE; // [RULE12]
      bbe_pkg::ST_DONE:
        if (tk.rst_valid)
          state_next = bbe_pkg::ST_RUN; // [RULE13]
      default:
        state_next = bbe_pkg::ST_LOCKOUT;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      state_reg <= bbe_pkg::ST_INIT;
    else
      state_reg <= state_next;
  end

  // sync beam masked on every path into the blanked set
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      blank_reg <= '0;
    else if (state_reg == bbe_pkg::ST_TEACH && dip_normal)
      blank_reg <= BEAM_BLOCKED_IN & ~BEAMS'(1); // [RULE4] [RULE5] [RULE14]
    else if (wr_pend_reg && wr_addr_reg == bbe_pkg::OFS_BLANK
             && remote_en_reg)
      blank_reg <= HWDATA_IN[BEAMS-1:0] & ~BEAMS'(1); // [RULE15] [RULE5]
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      SAFETY_PAIR_OUT <= 2'h0;
    else if (state_reg == bbe_pkg::ST_RUN && !trip && !blank_lost)
      SAFETY_PAIR_OUT <= 2'h3;
    else
      SAFETY_PAIR_OUT <= 2'h0; // [RULE2] [RULE6]
  end

  // indications derive from the current state and field
  logic st_green, st_red, rst_yel;
  logic [BEAMS-1:0] z_green, z_red;
  logic [7:0] disp;

  always_comb
  begin
    st_green = 1'b0;
    st_red = 1'b0;
    rst_yel = 1'b0;
    z_red = BEAM_BLOCKED_IN & ~blank_reg; // [RULE18]
    z_green = ~BEAM_BLOCKED_IN | (blank_reg & {BEAMS{tk.blink}}); // [RULE8]
    disp = count_ones(BEAM_BLOCKED_IN);
    case (state_reg)
      bbe_pkg::ST_RUN:
      begin
        st_green = !trip && (!rr_en || tk.blink); // [RULE3] [RULE16]
        st_red = trip; // [RULE16] [RULE19]
        rst_yel = 1'b1;
      end
      bbe_pkg::ST_LATCHED:
      begin
        st_red = 1'b1; // [RULE17]
        rst_yel = trip || tk.blink; // [RULE17]
      end
      bbe_pkg::ST_TEACH:
      begin
        st_red = 1'b1; // [RULE11]
        z_red = BEAM_BLOCKED_IN;
        z_green = ~BEAM_BLOCKED_IN;
        if (tk.blink)
          disp = bbe_pkg::DISP_TEACH_ACTIVE; // [RULE11]
      end
      bbe_pkg::ST_DONE:
      begin
        st_red = tk.sflash; // [RULE12]
        rst_yel = tk.sflash;
        z_red = '0;
        z_green = blank_reg & {BEAMS{tk.blink}};
        disp = bbe_pkg::DISP_TEACH_DONE;
      end
      bbe_pkg::ST_LOCKOUT:
      begin
        st_red = tk.sflash;
        z_red = '0;
        z_green = '0;
      end
      default:
      begin
        z_red = '0;
        z_green = '0;
      end
    endcase
    if (sync_blk && (state_reg == bbe_pkg::ST_RUN
                     || state_reg == bbe_pkg::ST_LATCHED))
    begin
      z_red = BEAMS'(1); // [RULE21]
      z_green = '0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      STATUS_GREEN_OUT <= 1'b0;
      STATUS_RED_OUT <= 1'b0;
      RESET_YEL_OUT <= 1'b0;
      ZONE_GREEN_OUT <= '0;
      ZONE_RED_OUT <= '0;
      DISP_CODE_OUT <= 8'h0;
    end
    else
    begin
      STATUS_GREEN_OUT <= st_green;
      STATUS_RED_OUT <= st_red;
      RESET_YEL_OUT <= rst_yel;
      ZONE_GREEN_OUT <= z_green;
      ZONE_RED_OUT <= z_red;
      DISP_CODE_OUT <= disp;
    end
  end

  // zero-wait slave: read data is registered during the address phase
  logic addr_ok;
  logic [31:0] rd_mux;
  assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN == bbe_pkg::HTRANS_NONSEQ
    && HSIZE_IN == bbe_pkg::HSIZE_WORD;

  always_comb
  begin
    rd_mux = 32'h0;
    case (HADDR_IN[7:0])
      bbe_pkg::OFS_CTRL:
        rd_mux[bbe_pkg::CTRL_REMOTE_BIT] = remote_en_reg;
      bbe_pkg::OFS_BLANK:
        rd_mux[BEAMS-1:0] = blank_reg;
      bbe_pkg::OFS_STATUS:
        rd_mux[7:0] = {2'h0, trip, SAFETY_PAIR_OUT[0], 1'b0, state_reg};
      bbe_pkg::OFS_BLOCKED:
        rd_mux[BEAMS-1:0] = BEAM_BLOCKED_IN;
      default:
        rd_mux = 32'h0;
    endcase
    if (HADDR_IN[31:8] != 24'h0)
      rd_mux = 32'h0;
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h0;
    end
    else
    begin
      wr_pend_reg <= addr_ok && HWRITE_IN && HADDR_IN[31:8] == 24'h0;
      wr_addr_reg <= HADDR_IN[7:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      HRDATA_OUT <= 32'h0;
    else if (addr_ok && !HWRITE_IN)
      HRDATA_OUT <= rd_mux;
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      remote_en_reg <= bbe_pkg::CTRL_RESET;
    else if (wr_pend_reg && wr_addr_reg == bbe_pkg::OFS_CTRL)
      remote_en_reg <= HWDATA_IN[bbe_pkg::CTRL_REMOTE_BIT];
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      HREADYOUT_OUT <= 1'b0;
      HRESP_OUT <= 1'b0;
    end
    else
    begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_trip_off;
    trip |=> SAFETY_PAIR_OUT == 2'h0;
  endproperty
  a_trip_off: assert property (p_trip_off) // [RULE2]
    else $error("outputs stayed on during trip");
  property p_rr_pair;
    state_reg == bbe_pkg::ST_RUN && rr_en && !sync_blk && !CASCADE_BLOCKED_IN
    && !blank_lost && excess_n == 8'h2 && |(excess & (excess >> 1))
    |=> SAFETY_PAIR_OUT == 2'h3;
  endproperty
  a_rr_pair: assert property (p_rr_pair) // [RULE1]
    else $error("adjacent pair tripped with reduced resolution");
  property p_lost_lock;
    (state_reg == bbe_pkg::ST_RUN || state_reg == bbe_pkg::ST_LATCHED)
    && blank_lost |=> state_reg == bbe_pkg::ST_LOCKOUT ##1 !STATUS_GREEN_OUT;
  endproperty
  a_lost_lock: assert property (p_lost_lock) // [RULE7]
    else $error("moved blanked object did not lock out");
  property p_sync_free;
    blank_reg[0] == 1'b0;
  endproperty
  a_sync_free: assert property (p_sync_free) // [RULE5]
    else $error("sync beam blanked");
  property p_latch_hold;
    state_reg == bbe_pkg::ST_LATCHED && !tk.rst_valid
    |=> state_reg != bbe_pkg::ST_RUN ##1 SAFETY_PAIR_OUT == 2'h0;
  endproperty
  a_latch_hold: assert property (p_latch_hold) // [RULE20]
    else $error("latch released without reset");
  property p_teach_ind;
    state_reg == bbe_pkg::ST_TEACH |=> STATUS_RED_OUT && !RESET_YEL_OUT;
  endproperty
  a_teach_ind: assert property (p_teach_ind) // [RULE11]
    else $error("teach indication wrong");
  property p_sync_zone;
    state_reg == bbe_pkg::ST_RUN && sync_blk
    |=> ZONE_RED_OUT == BEAMS'(1) && ZONE_GREEN_OUT == '0;
  endproperty
  a_sync_zone: assert property (p_sync_zone) // [RULE21]
    else $error("sync blockage zone display wrong");
  property p_done_hold;
    state_reg == bbe_pkg::ST_DONE && !tk.rst_valid
    |=> state_reg == bbe_pkg::ST_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold) // [RULE13]
    else $error("left teach-done without reset");
  property p_empty_teach;
    state_reg == bbe_pkg::ST_TEACH && dip_normal && BEAM_BLOCKED_IN == '0
    |=> blank_reg == '0 && state_reg == bbe_pkg::ST_DONE;
  endproperty
  a_empty_teach: assert property (p_empty_teach) // [RULE14]
    else $error("clear-field teach left beams blanked");

  c_teach_done: cover property (state_reg == bbe_pkg::ST_TEACH
    ##1 state_reg == bbe_pkg::ST_DONE);
  c_lockout: cover property (state_reg == bbe_pkg::ST_LOCKOUT);
  c_latch_rel: cover property (state_reg == bbe_pkg::ST_LATCHED
    ##1 state_reg == bbe_pkg::ST_RUN);
endmodule

// *** design/bbe_flasher.sv ***
// free-running blink and single-flash pattern generator
`timescale 1ns/1ps
module bbe_flasher #(
  parameter int unsigned HALF_CYC = bbe_pkg::BLINK_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  bbe_tick_if.flasher tk
);
  logic [31:0] cnt_reg;
  logic [1:0] phase_reg;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= 32'h0;
      phase_reg <= 2'h0;
    end
    else if (cnt_reg >= HALF_CYC - 1)
    begin
      cnt_reg <= 32'h0;
      phase_reg <= phase_reg + 2'h1;
    end
    else
      cnt_reg <= cnt_reg + 32'h1;
  end

  assign tk.blink = ~phase_reg[0];
  // single flash: one half-period lit in four
  assign tk.sflash = (phase_reg == 2'h0);
endmodule

// *** design/bbe_pkg.sv ***
// constants, states and register map of the beam blanking evaluator
package bbe_pkg;
  localparam int unsigned CLK_KHZ = 100_000;
  localparam int unsigned RST_MIN_MS = 250;
  localparam int unsigned RST_MAX_MS = 2000;
  // plain products of ms and kHz with no rounding; both are exact at 100 MHz
  localparam int unsigned RST_MIN_CYC = RST_MIN_MS * CLK_KHZ;
  localparam int unsigned RST_MAX_CYC = RST_MAX_MS * CLK_KHZ;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int unsigned BEAMS = 8;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BLANK = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BLOCKED = 8'h0C;
  localparam int unsigned CTRL_REMOTE_BIT = 0;
  localparam logic CTRL_RESET = 1'h0;

  // display codes; values above any beam count
  localparam logic [7:0] DISP_TEACH_ACTIVE = 8'hFA;
  localparam logic [7:0] DISP_TEACH_DONE = 8'hFC;

  // switch positions: bit0 latch1, bit1 redres1, bit2 latch2, bit3 redres2
  localparam logic [3:0] DIP_TEACH = 4'h6;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_RUN,
    ST_LATCHED,
    ST_LOCKOUT,
    ST_TEACH,
    ST_DONE
  } bbe_state_t;
endpackage

// *** design/bbe_rst_qual.sv ***
// reset switch qualifier: a closure of valid length gives one pulse
`timescale 1ns/1ps
module bbe_rst_qual #(
  parameter int unsigned MIN_CYC = bbe_pkg::RST_MIN_CYC,
  parameter int unsigned MAX_CYC = bbe_pkg::RST_MAX_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  bbe_tick_if.qual tk
);
  logic [31:0] cnt_reg;
  logic prev_reg;
  logic valid_reg;

  // saturate above max so a held switch can never wrap into range
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_reg <= 32'h0;
    else if (!tk.sw_closed)
      cnt_reg <= 32'h0;
    else if (cnt_reg <= MAX_CYC)
      cnt_reg <= cnt_reg + 32'h1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      prev_reg <= 1'b0;
    else
      prev_reg <= tk.sw_closed;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      valid_reg <= 1'b0;
    else
      valid_reg <= prev_reg && !tk.sw_closed && cnt_reg >= MIN_CYC
                   && cnt_reg <= MAX_CYC; // [RULE10] [RULE22]
  end

  assign tk.rst_valid = valid_reg;

  property p_valid_len;
    @(posedge clk_in) disable iff (rst_in)
    (prev_reg && !tk.sw_closed && (cnt_reg < MIN_CYC || cnt_reg > MAX_CYC))
    |=> !valid_reg;
  endproperty
  a_valid_len: assert property (p_valid_len) // [RULE22]
    else $error("reset accepted outside valid closure time");
endmodule

// *** design/bbe_tick_if.sv ***
// timing and reset-switch signals shared between the evaluator and helpers
`timescale 1ns/1ps
interface bbe_tick_if;
  logic blink;
  logic sflash;
  logic sw_closed;
  logic rst_valid;
  modport flasher (output blink, output sflash);
  modport qual (input sw_closed, output rst_valid);
  modport core (input blink, input sflash, input rst_valid,
                output sw_closed);
endinterface

// *** dv/bbe_machine_model.sv ***
// guarded machine control circuit fed by the safety output pair
`timescale 1ns/1ps
module bbe_machine_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] pair_in,
  output logic run_out,
  output logic fault_out
);
  logic mis_reg;

  // relay channels in series: one channel alone never powers the machine
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      run_out <= 1'b0;
    else
      run_out <= &pair_in;
  end

  // channels that disagree for two cycles running mean a lost channel
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mis_reg <= 1'b0;
      fault_out <= 1'b0;
    end
    else
    begin
      mis_reg <= ^pair_in;
      fault_out <= mis_reg & (^pair_in);
    end
  end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the beam blanking evaluator
`timescale 1ns/1ps
module tb_top;
  localparam int MINC = 5;
  localparam int MAXC = 40;
  localparam int K_RD = 0, K_RESP = 1, K_SAFE = 2, K_SRED = 3, K_ZRED = 4;
  localparam int K_ZGB = 5, K_DISP = 6, K_YEL = 7, K_SGRN = 8, K_MRUN = 9;
  localparam int K_FLT = 10;
  typedef struct {int kind; logic [31:0] v;} bbe_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] beams = 8'h00;
  logic casc = 1'b0;
  logic [3:0] dip = 4'h0;
  logic rsw = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, sgrn, sred, yel, mrun, mflt;
  logic [31:0] hrdata;
  logic [1:0] pair;
  logic [7:0] zgrn, zred, disp;
  logic [31:0] seed = 32'h0000331D;
  int err_count = 0;
  int samples_checked = 0;
  int idx;
  bbe_note_t q[$];
  bbe_note_t n;

  always #5 clk = ~clk;

  bbe_evaluator #(.RST_MIN_CYC(MINC), .RST_MAX_CYC(MAXC),
    .BLINK_HALF_CYC(4)) dut (.CORE_CLK_IN(clk), .RST_IN(rst),
    .BEAM_BLOCKED_IN(beams), .CASCADE_BLOCKED_IN(casc), .DIP_IN(dip),
    .RESET_SW_IN(rsw), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(bbe_pkg::HSIZE_WORD), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .SAFETY_PAIR_OUT(pair), .STATUS_GREEN_OUT(sgrn),
    .STATUS_RED_OUT(sred), .RESET_YEL_OUT(yel), .ZONE_GREEN_OUT(zgrn),
    .ZONE_RED_OUT(zred), .DISP_CODE_OUT(disp));

  bbe_machine_model partner (.clk_in(clk), .rst_in(rst), .pair_in(pair),
    .run_out(mrun), .fault_out(mflt));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] obs(input int k);
    case (k)
      K_RD: obs = hrdata;
      K_RESP: obs = {31'h0, hresp};
      K_SAFE: obs = {30'h0, pair};
      K_SRED: obs = {31'h0, sred};
      K_ZRED: obs = {24'h0, zred};
      K_ZGB: obs = {24'h0, zgrn & 8'h0C};
      K_DISP: obs = {24'h0, disp};
      K_YEL: obs = {31'h0, yel};
      K_SGRN: obs = {31'h0, sgrn};
      K_FLT: obs = {31'h0, mflt};
      default: obs = {31'h0, mrun};
    endcase
  endfunction

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  task automatic cmp_lamp(input logic [31:0] got, input logic [31:0] exp);
    cmp_reg(got, exp);
  endtask

  // the watcher drains every queued note, oldest first, once outputs have settled
  always @(negedge clk)
  begin
    while (q.size() > 0)
    begin
      n = q.pop_front();
      if (n.kind == K_RD || n.kind == K_RESP)
        cmp_reg(obs(n.kind), n.v);
      else
        cmp_lamp(obs(n.kind), n.v);
    end
  end

  task automatic note(input int k, input logic [31:0] v);
    q.push_back('{k, v});
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic count(input int k, input logic [31:0] v, output int h);
    h = 0;
    repeat (40)
    begin
      @(negedge clk);
      if (obs(k) === v)
        h++;
    end
    @(posedge clk);
  endtask

  // flashing means both levels show within the window
  task automatic blinks(input int k, input logic [31:0] v);
    int h;
    count(k, v, h);
    cmp_lamp({31'h0, (h > 0) && (h < 40)}, 32'h1);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] exp);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= bbe_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    if (!wr)
      note(K_RD, exp);
    note(K_RESP, 32'h0);
  endtask

  task automatic put(input logic [7:0] b, input logic [1:0] s,
                     input logic [7:0] zr);
    beams <= b;
    cyc(4);
    note(K_SAFE, {30'h0, s});
    note(K_MRUN, {31'h0, &s});
    note(K_FLT, 32'h0);
    note(K_ZRED, {24'h0, zr});
  endtask

  task automatic press(input int k);
    rsw <= 1'b1;
    cyc(k);
    rsw <= 1'b0;
    cyc(8);
  endtask

  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    stop_test();
  end

  initial
  begin
    int h;
    cyc(2);
    rst <= 1'b0;
    put(8'h00, 2'h3, 8'h00);
    put(8'h08, 2'h0, 8'h08);
    note(K_SRED, 32'h1);
    put(8'h00, 2'h3, 8'h00);
    note(K_SRED, 32'h0);
    note(K_SGRN, 32'h1);
    repeat (4)
    begin
      idx = 1 + int'(xs() % 7);
      put(8'h01 << idx, 2'h0, 8'h01 << idx);
    end
    casc <= 1'b1;
    put(8'h00, 2'h0, 8'h00);
    note(K_SRED, 32'h1);
    casc <= 1'b0;
    dip <= 4'hA;
    put(8'h00, 2'h3, 8'h00);
    blinks(K_SGRN, 32'h1);
    put(8'h30, 2'h3, 8'h30);
    put(8'h14, 2'h0, 8'h14);
    put(8'h03, 2'h0, 8'h01);
    put(8'h00, 2'h3, 8'h00);
    dip <= 4'h5;
    put(8'h04, 2'h0, 8'h04);
    count(K_YEL, 32'h1, h);
    cmp_lamp(h, 32'd40);
    put(8'h00, 2'h0, 8'h00);
    note(K_SRED, 32'h1);
    blinks(K_YEL, 32'h1);
    press(3);
    note(K_SAFE, 32'h0);
    press(MAXC + 5);
    note(K_SAFE, 32'h0);
    press(MINC);
    note(K_SAFE, 32'h3);
    // operator side of the teach sequence, sync beam blocked on purpose
    dip <= 4'h0;
    put(8'h0D, 2'h0, 8'h01);
    dip <= bbe_pkg::DIP_TEACH;
    cyc(4);
    press(MINC);
    note(K_SRED, 32'h1);
    note(K_YEL, 32'h0);
    note(K_ZRED, 32'h0D);
    blinks(K_DISP, bbe_pkg::DISP_TEACH_ACTIVE);
    blinks(K_DISP, 32'h3);
    dip <= 4'h0;
    cyc(4);
    note(K_DISP, bbe_pkg::DISP_TEACH_DONE);
    note(K_SAFE, 32'h0);
    blinks(K_YEL, 32'h1);
    blinks(K_SRED, 32'h1);
    blinks(K_ZGB, 32'h0C);
    bus(1'b0, bbe_pkg::OFS_BLANK, 32'h0, 32'h0C);
    press(MAXC);
    put(8'h0C, 2'h3, 8'h00);
    blinks(K_ZGB, 32'h0C);
    put(8'h04, 2'h0, 8'h00);
    note(K_YEL, 32'h0);
    blinks(K_SRED, 32'h1);
    beams <= 8'h00;
    dip <= bbe_pkg::DIP_TEACH;
    cyc(4);
    press(MINC);
    blinks(K_DISP, 32'h0);
    dip <= 4'h0;
    cyc(4);
    bus(1'b0, bbe_pkg::OFS_BLANK, 32'h0, 32'h0);
    press(MINC);
    note(K_SAFE, 32'h3);
    put(8'h36, 2'h0, 8'h36);
    bus(1'b1, bbe_pkg::OFS_BLANK, 32'h36, 32'h0);
    bus(1'b0, bbe_pkg::OFS_BLANK, 32'h0, 32'h0);
    bus(1'b1, bbe_pkg::OFS_CTRL, 32'h1, 32'h0);
    bus(1'b0, bbe_pkg::OFS_CTRL, 32'h0, 32'h1);
    bus(1'b1, bbe_pkg::OFS_BLANK, 32'h37, 32'h0);
    bus(1'b0, bbe_pkg::OFS_BLANK, 32'h0, 32'h36);
    put(8'h36, 2'h3, 8'h00);
    bus(1'b0, bbe_pkg::OFS_STATUS, 32'h0, 32'h11);
    bus(1'b0, bbe_pkg::OFS_BLOCKED, 32'h0, 32'h36);
    bus(1'b0, 8'h40, 32'h0, 32'h0);
    cyc(2);
    stop_test();
  end
endmodule
